// ### rtl/plb_pkg.sv
/*
  Shared constants and state types for both ends of the parallel burst
  link. Assumes a 100 MHz system clock at each end and a 32-bit bus.
*/
package plb_pkg;
  localparam int         DATA_W         = 32;
  localparam int         SYS_PERIOD_NS  = 10;
  localparam int         LINK_PERIOD_NS = 40;
  localparam int         LINK_DIV       = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [1:0] PHASE_LAST     = 2'(LINK_DIV - 1);
  localparam logic [1:0] PHASE_HIGH     = 2'(LINK_DIV / 2);
  localparam int         BURST_WORDS    = 256;
  localparam logic [7:0] BURST_LAST     = 8'(BURST_WORDS - 1);
  localparam logic [8:0] BURST_COUNT    = 9'(BURST_WORDS);
  localparam logic [1:0] GAP_MIN_PER    = 2'h2;
  localparam logic [1:0] PKT_LOW_MIN    = 2'h2;
  localparam logic [1:0] CNT2_SAT       = 2'h3;
  localparam logic [5:0] GRANT_MAX      = 6'h3f;
  localparam logic [2:0] DEB_LAST       = 3'h7;
  localparam logic [3:0] HOLD_MIN_PER   = 4'h4;
  localparam logic [3:0] REJECT_PER     = 4'h8;
  localparam logic [3:0] HOLD_SAT       = 4'hf;
  localparam logic [5:0] BUF_NUM        = 6'h04;
  localparam logic [5:0] CREDIT_MAX     = 6'h3f;

  typedef enum logic [2:0] {
    PLB_S_IDLE  = 3'h0,
    PLB_S_CALL  = 3'h1,
    PLB_S_OPEN  = 3'h2,
    PLB_S_BURST = 3'h3,
    PLB_S_CHECK = 3'h4
  } plb_src_state_e;

  typedef enum logic [1:0] {
    PLB_D_IDLE   = 2'h0,
    PLB_D_OPEN   = 2'h1,
    PLB_D_REJECT = 2'h2
  } plb_dst_state_e;
endpackage

// ### rtl/plb_link_if.sv
/*
  Wires of the parallel burst link between sending and receiving ends.
  Assumes the bench joins two ends and supplies no clock of its own.
*/
`timescale 1ns/10ps
`default_nettype none
interface plb_link_if;
  logic                        link_clk;
  logic [plb_pkg::DATA_W-1:0]  data;
  logic                        request;
  logic                        packet;
  logic                        burst;
  logic                        cable_src;
  logic                        connect;
  logic                        ready;
  logic                        cable_dst;

  modport src (
    output link_clk, data, request, packet, burst, cable_src,
    input  connect, ready, cable_dst
  );
  modport dst (
    input  link_clk, data, request, packet, burst, cable_src,
    output connect, ready, cable_dst
  );
endinterface
`default_nettype wire

// ### rtl/plb_source.sv
/*
  Sending end of the parallel burst link: makes the link clock, opens
  connections, frames packets and bursts, and tracks grants.
  Assumes the receiving end sits on the far side of plb_link_if and that
  the user presents burst words as they are taken.
*/
`timescale 1ns/10ps
`default_nettype none
module plb_source (
  input  wire logic                       i_clock,
  input  wire logic                       i_arst_n,
  plb_link_if.src                         link,
  input  wire logic                       i_call,
  input  wire logic [plb_pkg::DATA_W-1:0] i_ifield,
  input  wire logic                       i_packet,
  input  wire logic                       i_burst_req,
  input  wire logic [plb_pkg::DATA_W-1:0] i_word,
  output logic                            o_open,
  output logic                            o_word_take,
  output logic                            o_burst_busy,
  output logic [5:0]                      o_grants
);
  plb_pkg::plb_src_state_e     state_reg, state_next;
  logic [1:0]                  phase_reg, phase_next;
  logic                        clk_reg, clk_next;
  logic [plb_pkg::DATA_W-1:0]  data_reg, data_next;
  logic [plb_pkg::DATA_W-1:0]  lrc_reg, lrc_next;
  logic                        req_reg, req_next;
  logic                        pkt_reg, pkt_next;
  logic                        burst_reg, burst_next;
  logic                        take_reg, take_next;
  logic                        open_reg, open_next;
  logic [7:0]                  cnt_reg, cnt_next;
  logic [5:0]                  grant_reg, grant_next;
  logic [1:0]                  gap_reg, gap_next;
  logic [1:0]                  plow_reg, plow_next;
  logic [2:0]                  sync1_reg, sync1_next;
  logic [2:0]                  sync2_reg, sync2_next;
  logic [1:0]                  filt_reg, filt_next;
  logic [1:0][2:0]             deb_reg, deb_next;
  logic                        tick;
  logic                        conn_ok;
  logic                        cable_ok;
  logic                        g_inc;
  logic                        g_dec;
  logic                        linked;

  // Link-side outputs come straight from registers, except cable_src, which is tied high
  assign link.link_clk  = clk_reg;
  assign link.data      = data_reg;
  assign link.request   = req_reg;
  assign link.packet    = pkt_reg;
  assign link.burst     = burst_reg;
  assign link.cable_src = 1'b1;
  assign o_open         = open_reg;
  assign o_word_take    = take_reg;
  assign o_burst_busy   = burst_reg;
  assign o_grants       = grant_reg;

  // Next-state logic for the whole sending end
  always_comb begin
    // Two-stage synchronisers for accept, grant and cable lines
    sync1_next = {link.cable_dst, link.ready, link.connect};
    sync2_next = sync1_reg;
    // Accept and grant carry no clock, so a change must persist
    // eight system cycles before it counts; this trades latency
    // for immunity to cable noise
    filt_next = filt_reg;
    deb_next  = deb_reg;
    for (int i = 0; i < 2; i++) begin
      if (sync2_reg[i] != filt_reg[i]) begin
        deb_next[i] = deb_reg[i] + 3'h1;
        if (deb_reg[i] == plb_pkg::DEB_LAST) begin
          filt_next[i] = sync2_reg[i];
          deb_next[i]  = 3'h0;
        end
      end else begin
        deb_next[i] = 3'h0;
      end
    end
    conn_ok  = filt_reg[0];
    cable_ok = sync2_reg[2];

    // Free-running divider: the link clock never pauses
    if (phase_reg == plb_pkg::PHASE_LAST) begin
      phase_next = 2'h0;
    end else begin
      phase_next = phase_reg + 2'h1;
    end
    clk_next = (phase_next < plb_pkg::PHASE_HIGH);
    // Line updates land on the same edge that raises the link clock
    tick = (phase_reg == plb_pkg::PHASE_LAST);

    state_next = state_reg;
    data_next  = data_reg;
    lrc_next   = lrc_reg;
    req_next   = req_reg;
    pkt_next   = pkt_reg;
    burst_next = burst_reg;
    take_next  = 1'b0;
    open_next  = open_reg;
    cnt_next   = cnt_reg;
    gap_next   = gap_reg;
    plow_next  = plow_reg;
    g_dec      = 1'b0;
    linked     = (state_reg != plb_pkg::PLB_S_IDLE) &&
                 (state_reg != plb_pkg::PLB_S_CALL);
    g_inc      = linked && filt_next[1] && !filt_reg[1];

    if (!cable_ok) begin
      // Far end unpowered or unplugged: drop everything at once
      state_next = plb_pkg::PLB_S_IDLE;
      req_next   = 1'b0;
      pkt_next   = 1'b0;
      burst_next = 1'b0;
      open_next  = 1'b0;
      g_inc      = 1'b0;
    end else if (tick) begin
      unique case (state_reg)
        plb_pkg::PLB_S_IDLE: begin
          // A new call waits until the old accept has been seen low
          if (i_call && !conn_ok) begin
            data_next  = i_ifield;
            req_next   = 1'b1;
            state_next = plb_pkg::PLB_S_CALL;
          end
        end
        plb_pkg::PLB_S_CALL: begin
          // Information word stays put while waiting for accept
          if (!i_call) begin
            req_next   = 1'b0;
            state_next = plb_pkg::PLB_S_IDLE;
          end else if (conn_ok) begin
            open_next  = 1'b1;
            gap_next   = plb_pkg::CNT2_SAT;
            plow_next  = plb_pkg::CNT2_SAT;
            state_next = plb_pkg::PLB_S_OPEN;
          end
        end
        plb_pkg::PLB_S_OPEN: begin
          if (gap_reg != plb_pkg::CNT2_SAT) begin
            gap_next = gap_reg + 2'h1;
          end
          if (!pkt_reg && plow_reg != plb_pkg::CNT2_SAT) begin
            plow_next = plow_reg + 2'h1;
          end
          if (!conn_ok) begin
            // Receiver broke the connection: release all lines
            req_next   = 1'b0;
            pkt_next   = 1'b0;
            open_next  = 1'b0;
            state_next = plb_pkg::PLB_S_IDLE;
          end else if (!i_call && !pkt_reg) begin
            req_next   = 1'b0;
            open_next  = 1'b0;
            state_next = plb_pkg::PLB_S_IDLE;
          end else if (pkt_reg && !i_packet) begin
            pkt_next  = 1'b0;
            plow_next = 2'h0;
          end else if (!pkt_reg && i_packet &&
                       plow_reg >= plb_pkg::PKT_LOW_MIN - 2'h1) begin
            // Raised on accept alone; grants play no part
            pkt_next = 1'b1;
          end else if (pkt_reg && i_burst_req &&
                       grant_reg != 6'h00 &&
                       gap_reg >= plb_pkg::GAP_MIN_PER - 2'h1) begin
            data_next  = i_word;
            lrc_next   = i_word;
            burst_next = 1'b1;
            take_next  = 1'b1;
            cnt_next   = 8'h00;
            g_dec      = 1'b1;
            state_next = plb_pkg::PLB_S_BURST;
          end
        end
        plb_pkg::PLB_S_BURST: begin
          // Word 256 went out on the previous tick, so close the burst
          if (cnt_reg == plb_pkg::BURST_LAST) begin
            burst_next = 1'b0;
            data_next  = lrc_reg;
            state_next = plb_pkg::PLB_S_CHECK;
          end else begin
            // Words follow every period with no holes
            data_next = i_word;
            lrc_next  = lrc_reg ^ i_word;
            take_next = 1'b1;
            cnt_next  = cnt_reg + 8'h01;
          end
        end
        plb_pkg::PLB_S_CHECK: begin
          data_next  = '0;
          gap_next   = 2'h0;
          state_next = plb_pkg::PLB_S_OPEN;
        end
        default: begin
          state_next = plb_pkg::PLB_S_IDLE;
        end
      endcase
    end

    // Grant count: cleared on each call, saturates at 63
    if (state_reg == plb_pkg::PLB_S_IDLE) begin
      grant_next = 6'h00;
    end else begin
      unique case ({g_inc, g_dec})
        2'b10: begin
          grant_next = (grant_reg == plb_pkg::GRANT_MAX) ?
                       grant_reg : grant_reg + 6'h01;
        end
        2'b01: begin
          grant_next = grant_reg - 6'h01;
        end
        default: begin
          grant_next = grant_reg;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= plb_pkg::PLB_S_IDLE;
      phase_reg <= 2'h0;
      clk_reg   <= 1'b1;
      data_reg  <= '0;
      lrc_reg   <= '0;
      req_reg   <= 1'b0;
      pkt_reg   <= 1'b0;
      burst_reg <= 1'b0;
      take_reg  <= 1'b0;
      open_reg  <= 1'b0;
      cnt_reg   <= 8'h00;
      grant_reg <= 6'h00;
      gap_reg   <= plb_pkg::CNT2_SAT;
      plow_reg  <= plb_pkg::CNT2_SAT;
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      filt_reg  <= 2'h0;
      deb_reg   <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      clk_reg   <= clk_next;
      data_reg  <= data_next;
      lrc_reg   <= lrc_next;
      req_reg   <= req_next;
      pkt_reg   <= pkt_next;
      burst_reg <= burst_next;
      take_reg  <= take_next;
      open_reg  <= open_next;
      cnt_reg   <= cnt_next;
      grant_reg <= grant_next;
      gap_reg   <= gap_next;
      plow_reg  <= plow_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      filt_reg  <= filt_next;
      deb_reg   <= deb_next;
    end
  end
endmodule
`default_nettype wire

// ### rtl/plb_dest.sv
/*
  Receiving end of the parallel burst link: answers calls, issues grants
  within its free buffers, and checks each burst against its check word.
  Assumes the sending end makes the link clock; all link lines are
  synchronised to the local 100 MHz clock before use.
*/
`timescale 1ns/10ps
`default_nettype none
module plb_dest (
  input  wire logic                  i_clock,
  input  wire logic                  i_arst_n,
  plb_link_if.dst                    link,
  input  wire logic                  i_accept,
  input  wire logic                  i_buf_free,
  output logic                       o_open,
  output logic [plb_pkg::DATA_W-1:0] o_ifield,
  output logic                       o_packet,
  output logic                       o_word_valid,
  output logic [plb_pkg::DATA_W-1:0] o_word,
  output logic                       o_burst_done,
  output logic                       o_check_err
);
  plb_pkg::plb_dst_state_e    state_reg, state_next;
  logic [4:0]                 sy1_reg, sy1_next, sy2_reg, sy2_next;
  logic [plb_pkg::DATA_W-1:0] dy1_reg, dy1_next, dy2_reg, dy2_next;
  logic                       clkd_reg, clkd_next;
  logic                       conn_reg, conn_next;
  logic                       rdy_reg, rdy_next;
  logic [3:0]                 hcnt_reg, hcnt_next;
  logic [3:0]                 rcnt_reg, rcnt_next;
  logic [5:0]                 cred_reg, cred_next;
  logic [plb_pkg::DATA_W-1:0] ifl_reg, ifl_next;
  logic [plb_pkg::DATA_W-1:0] lrc_reg, lrc_next;
  logic [plb_pkg::DATA_W-1:0] word_reg, word_next;
  logic [8:0]                 wcnt_reg, wcnt_next;
  logic                       inb_reg, inb_next;
  logic                       pkt_reg, pkt_next;
  logic                       wv_reg, wv_next;
  logic                       done_reg, done_next;
  logic                       err_reg, err_next;
  logic                       fall;
  logic                       s_req;
  logic                       s_pkt;
  logic                       s_burst;

  assign link.connect   = conn_reg;
  assign link.ready     = rdy_reg;
  assign link.cable_dst = 1'b1;
  assign o_open         = conn_reg;
  assign o_ifield       = ifl_reg;
  assign o_packet       = pkt_reg;
  assign o_word_valid   = wv_reg;
  assign o_word         = word_reg;
  assign o_burst_done   = done_reg;
  assign o_check_err    = err_reg;

  // Next-state logic for the whole receiving end
  always_comb begin
    sy1_next  = {link.cable_src, link.burst, link.packet, link.request,
                 link.link_clk};
    sy2_next  = sy1_reg;
    dy1_next  = link.data;
    dy2_next  = dy1_reg;
    clkd_next = sy2_reg[0];
    // Clock and data share sync depth, so data is sampled mid-period
    fall      = clkd_reg && !sy2_reg[0];
    s_req     = sy2_reg[1];
    s_pkt     = sy2_reg[2];
    s_burst   = sy2_reg[3];

    state_next = state_reg;
    conn_next  = conn_reg;
    rdy_next   = rdy_reg;
    hcnt_next  = hcnt_reg;
    rcnt_next  = rcnt_reg;
    ifl_next   = ifl_reg;
    lrc_next   = lrc_reg;
    word_next  = word_reg;
    wcnt_next  = wcnt_reg;
    inb_next   = inb_reg;
    pkt_next   = pkt_reg;
    wv_next    = 1'b0;
    done_next  = 1'b0;
    err_next   = 1'b0;
    cred_next  = (i_buf_free && cred_reg != plb_pkg::CREDIT_MAX) ?
                 cred_reg + 6'h01 : cred_reg;

    if (!sy2_reg[4]) begin
      // No cable: link lines are meaningless, go quiet
      state_next = plb_pkg::PLB_D_IDLE;
      conn_next  = 1'b0;
      rdy_next   = 1'b0;
      inb_next   = 1'b0;
      pkt_next   = 1'b0;
    end else if (fall) begin
      if (hcnt_reg != plb_pkg::HOLD_SAT) begin
        hcnt_next = hcnt_reg + 4'h1;
      end
      if (rcnt_reg != plb_pkg::HOLD_SAT) begin
        rcnt_next = rcnt_reg + 4'h1;
      end
      unique case (state_reg)
        plb_pkg::PLB_D_IDLE: begin
          if (s_req && hcnt_reg >= plb_pkg::HOLD_MIN_PER) begin
            ifl_next   = dy2_reg;
            conn_next  = 1'b1;
            hcnt_next  = 4'h0;
            cred_next  = plb_pkg::BUF_NUM;
            inb_next   = 1'b0;
            state_next = i_accept ? plb_pkg::PLB_D_OPEN :
                                    plb_pkg::PLB_D_REJECT;
          end
        end
        plb_pkg::PLB_D_REJECT: begin
          // Accept is shown briefly then withdrawn, with no grants
          if (hcnt_reg >= plb_pkg::REJECT_PER - 4'h1) begin
            conn_next  = 1'b0;
            hcnt_next  = 4'h0;
            state_next = plb_pkg::PLB_D_IDLE;
          end
        end
        plb_pkg::PLB_D_OPEN: begin
          pkt_next = s_pkt;
          if (!s_req && hcnt_reg >= plb_pkg::HOLD_MIN_PER - 4'h1) begin
            conn_next  = 1'b0;
            rdy_next   = 1'b0;
            hcnt_next  = 4'h0;
            pkt_next   = 1'b0;
            state_next = plb_pkg::PLB_D_IDLE;
          end else if (rcnt_reg >= plb_pkg::HOLD_MIN_PER - 4'h1) begin
            if (rdy_reg) begin
              rdy_next  = 1'b0;
              rcnt_next = 4'h0;
            end else if (cred_reg != 6'h00 &&
                         hcnt_reg >= plb_pkg::HOLD_MIN_PER - 4'h1) begin
              // One pulse per free buffer; a free pulse this cycle stays
              rdy_next  = 1'b1;
              rcnt_next = 4'h0;
              cred_next = cred_next - 6'h01;
            end
          end
          // Any gap length after the check word is accepted
          if (s_burst) begin
            inb_next  = 1'b1;
            wv_next   = 1'b1;
            word_next = dy2_reg;
            lrc_next  = (inb_reg ? lrc_reg : '0) ^ dy2_reg;
            wcnt_next = inb_reg ? wcnt_reg + 9'h001 : 9'h001;
          end else if (inb_reg) begin
            inb_next  = 1'b0;
            done_next = 1'b1;
            err_next  = (lrc_reg != dy2_reg) ||
                        (wcnt_reg != plb_pkg::BURST_COUNT);
          end
        end
        default: begin
          state_next = plb_pkg::PLB_D_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= plb_pkg::PLB_D_IDLE;
      sy1_reg   <= 5'h00;
      sy2_reg   <= 5'h00;
      dy1_reg   <= '0;
      dy2_reg   <= '0;
      clkd_reg  <= 1'b0;
      conn_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      hcnt_reg  <= plb_pkg::HOLD_SAT;
      rcnt_reg  <= plb_pkg::HOLD_SAT;
      cred_reg  <= 6'h00;
      ifl_reg   <= '0;
      lrc_reg   <= '0;
      word_reg  <= '0;
      wcnt_reg  <= 9'h000;
      inb_reg   <= 1'b0;
      pkt_reg   <= 1'b0;
      wv_reg    <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      sy1_reg   <= sy1_next;
      sy2_reg   <= sy2_next;
      dy1_reg   <= dy1_next;
      dy2_reg   <= dy2_next;
      clkd_reg  <= clkd_next;
      conn_reg  <= conn_next;
      rdy_reg   <= rdy_next;
      hcnt_reg  <= hcnt_next;
      rcnt_reg  <= rcnt_next;
      cred_reg  <= cred_next;
      ifl_reg   <= ifl_next;
      lrc_reg   <= lrc_next;
      word_reg  <= word_next;
      wcnt_reg  <= wcnt_next;
      inb_reg   <= inb_next;
      pkt_reg   <= pkt_next;
      wv_reg    <= wv_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
    end
  end
endmodule
`default_nettype wire

// ### sim/plb_link_chk.sv
/*
  Assertions on the wires joining the two ends of the burst link.
  Assumes the 100 MHz clock and reset shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module plb_link_chk (
  input wire logic                       i_clock,
  input wire logic                       i_arst_n,
  input wire logic                       link_clk,
  input wire logic [plb_pkg::DATA_W-1:0] data,
  input wire logic                       request,
  input wire logic                       packet,
  input wire logic                       burst,
  input wire logic                       connect,
  input wire logic                       ready
);
  logic                       lclk_reg;
  logic                       pb_reg;
  logic                       pb_next;
  logic                       fall;
  logic [8:0]                 wcnt_reg;
  logic [8:0]                 wcnt_next;
  logic [plb_pkg::DATA_W-1:0] acc_reg;
  logic [plb_pkg::DATA_W-1:0] acc_next;

  // Tally taken mid-period, where source lines have long settled
  always_comb begin
    fall      = lclk_reg & ~link_clk;
    pb_next   = fall ? burst : pb_reg;
    wcnt_next = fall ? (burst ? wcnt_reg + 9'h1 : 9'h0) : wcnt_reg;
    acc_next  = fall ? (burst ? acc_reg ^ data : '0) : acc_reg;
  end

  // Link clock idles high in reset, so no false edge on release
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lclk_reg <= 1'b1;
      pb_reg   <= 1'b0;
      wcnt_reg <= 9'h0;
      acc_reg  <= '0;
    end else begin
      lclk_reg <= link_clk;
      pb_reg   <= pb_next;
      wcnt_reg <= wcnt_next;
      acc_reg  <= acc_next;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  property p_clk;
    $rose(link_clk) |=> link_clk ##1 (!link_clk)[*2] ##1 link_clk;
  endproperty
  a_clk: assert property (p_clk) else $error("link clock shape");
  property p_edge;
    $changed({data, request, packet, burst}) |-> $rose(link_clk);
  endproperty
  a_edge: assert property (p_edge) else $error("line off rise");
  property p_pkt; $rose(packet) |-> connect; endproperty
  a_pkt: assert property (p_pkt) else $error("packet early");
  property p_ifh; $rose(request) |=> $stable(data) until connect; endproperty
  a_ifh: assert property (p_ifh) else $error("info moved");
  property p_ans; $rose(request) |-> ##[1:80] connect; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_chk;
    fall && !burst && pb_reg |-> wcnt_reg == 9'h100 && data == acc_reg;
  endproperty
  a_chk: assert property (p_chk)
    else $error("burst or check word");
  property p_gap; fall && !burst && pb_reg |=> (!burst)[*8]; endproperty
  a_gap: assert property (p_gap) else $error("gap short");
  property p_rdy; $rose(ready) |-> ready[*8] ##1 ready[*8]; endproperty
  a_rdy: assert property (p_rdy) else $error("grant short");
  property p_rdn; $fell(ready) |-> (!ready)[*8] ##1 (!ready)[*8]; endproperty
  a_rdn: assert property (p_rdn) else $error("grant gap short");
  property p_con; $rose(connect) |-> connect[*8] ##1 connect[*8]; endproperty
  a_con: assert property (p_con) else $error("accept short");
  property p_gnt; $rose(ready) |-> $past(connect, 16); endproperty
  a_gnt: assert property (p_gnt) else $error("grant early");
  property p_end; $fell(request) |-> ##[1:80] !connect; endproperty
  a_end: assert property (p_end) else $error("accept kept");
  property p_plo; $fell(packet) |=> (!packet)[*7]; endproperty
  a_plo: assert property (p_plo) else $error("packet gap");
endmodule
`default_nettype wire

// ### sim/parallel_link_burst_protocol_tb.sv
/*
  Bench joining both link ends back to back through the link interface.
  Assumes the sending end makes the link clock and both cables present.
*/
`timescale 1ns/10ps
`default_nettype none
module parallel_link_burst_protocol_tb;
  logic        i_clock, i_arst_n, call, pkt, breq, accept, buf_free;
  logic        s_open, take, busy, d_open, d_pkt, wvalid, done, err;
  logic [5:0]  grants;
  logic [31:0] ifield, d_ifield, d_word;
  // Word stream start; only the feed process drives these afterwards
  logic [31:0] word     = 32'h5a00_0f01;
  logic [31:0] exp_word = 32'h5a00_0f01;
  int          n_mismatch, checks_done, cyc, nwords, ndone;

  plb_link_if plb_link_if_inst ();
  plb_source plb_source_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(plb_link_if_inst), .i_call(call), .i_ifield(ifield),
    .i_packet(pkt), .i_burst_req(breq), .i_word(word), .o_open(s_open),
    .o_word_take(take), .o_burst_busy(busy), .o_grants(grants));
  plb_dest plb_dest_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(plb_link_if_inst), .i_accept(accept), .i_buf_free(buf_free),
    .o_open(d_open), .o_ifield(d_ifield), .o_packet(d_pkt),
    .o_word_valid(wvalid), .o_word(d_word), .o_burst_done(done),
    .o_check_err(err));
  plb_link_chk plb_link_chk_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link_clk(plb_link_if_inst.link_clk), .data(plb_link_if_inst.data),
    .request(plb_link_if_inst.request), .packet(plb_link_if_inst.packet),
    .burst(plb_link_if_inst.burst), .connect(plb_link_if_inst.connect),
    .ready(plb_link_if_inst.ready));

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // 100 MHz system clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Hang guard well past the longest expected run
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Feed a counting word stream; receiver must see it unbroken and in order
  always @(posedge i_clock) begin
    if (take) word <= word + 32'h1;
    if (wvalid) begin
      chk("word", exp_word, d_word);
      exp_word++;
      nwords++;
    end
    if (done) begin
      chk("words", 32'h100, nwords);
      chk("check err", 32'h0, {31'h0, err});
      nwords = 0;
      ndone++;
    end
  end

  task automatic t_connect(input logic [31:0] f);
    @(posedge i_clock);
    ifield <= f;
    accept <= 1'b1;
    call   <= 1'b1;
    for (int i = 0; i < 300 && s_open !== 1'b1; i++) @(posedge i_clock);
    chk("dst ifield", f, d_ifield);
    for (int i = 0; i < 500 && grants !== 6'h04; i++) @(posedge i_clock);
    chk("grants", 32'h4, {26'h0, grants});
    $display("test connect done");
  endtask

  // Grants run out after four bursts; one freed buffer lets one more go
  task automatic t_bursts();
    pkt  <= 1'b1;
    breq <= 1'b1;
    for (int i = 0; i < 6000 && ndone < 4; i++) @(posedge i_clock);
    chk("bursts", 32'h4, ndone);
    chk("dst packet", 32'h1, {31'h0, d_pkt});
    repeat (200) @(posedge i_clock);
    chk("idle busy", 32'h0, {31'h0, busy});
    chk("spent", 32'h0, {26'h0, grants});
    buf_free <= 1'b1;
    @(posedge i_clock);
    buf_free <= 1'b0;
    for (int i = 0; i < 2000 && ndone < 5; i++) @(posedge i_clock);
    chk("credit burst", 32'h5, ndone);
    breq <= 1'b0;
    $display("test bursts done");
  endtask

  task automatic t_disconnect();
    pkt <= 1'b0;
    repeat (20) @(posedge i_clock);
    call <= 1'b0;
    for (int i = 0; i < 300 && {s_open, d_open} !== 2'h0; i++)
      @(posedge i_clock);
    chk("open", 32'h0, {30'h0, s_open, d_open});
    $display("test disconnect done");
  endtask

  // Refused call: accept shows for a bounded span and no grant arrives
  task automatic t_reject();
    int n;
    n = 0;
    accept <= 1'b0;
    call   <= 1'b1;
    for (int i = 0; i < 300 && d_open !== 1'b1; i++) @(posedge i_clock);
    for (int i = 0; i < 300 && d_open !== 1'b0; i++) begin
      @(posedge i_clock);
      n++;
    end
    chk("reject span", 32'h1, {31'h0, n >= 16 && n <= 64});
    chk("reject grants", 32'h0, {26'h0, grants});
    call <= 1'b0;
    $display("test reject done");
  endtask

  initial begin
    {i_arst_n, call, pkt, breq, accept, buf_free} = 6'h0;
    ifield   = 32'h0;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_connect(32'hc0de_5a01);
    t_bursts();
    t_disconnect();
    t_connect(32'h0f0f_a5a5);
    t_disconnect();
    t_reject();
    tally_and_finish();
  end
endmodule
`default_nettype wire
